// ===== verilog/asr_pkg.sv
// constants for the asynchronous static ram host controller
package asr_pkg;
  localparam int unsigned ADDR_W     = 15;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned WORDS      = 32768;
  localparam int unsigned CLK_PER_NS = 20;
  // slowest speed grade figures, in ns
  localparam int unsigned T_ACC_NS   = 150;
  localparam int unsigned T_WP_NS    = 80;
  localparam int unsigned T_SETUP_NS = 90;
  localparam int unsigned T_DIS_NS   = 45;
  // least times round up, then two cycles for the input synchroniser on the access time only
  localparam int unsigned ACC_CYC    = (T_ACC_NS + CLK_PER_NS - 1) / CLK_PER_NS + 2;
  localparam int unsigned WP_CYC     = (T_WP_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int unsigned SETUP_CYC  = (T_SETUP_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int unsigned DIS_CYC    = (T_DIS_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int unsigned CNT_W      = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
  typedef enum logic [2:0] {
    ASR_IDLE  = 3'b000,
    ASR_RSEL  = 3'b001,
    ASR_RWAIT = 3'b010,
    ASR_WSTB  = 3'b011,
    ASR_WEND  = 3'b100,
    ASR_TURN  = 3'b101
  } asr_state_t;
endpackage : asr_pkg

// ===== verilog/asr_cnt_if.sv
// timer carrier between controller and its delay counter
`timescale 1ns/1ps
interface asr_cnt_if;
  logic                             load;
  logic [asr_pkg::CNT_W-1:0]        value;
  logic                             done;
  modport ctl (output load, output value, input done);
  modport tmr (input load, input value, output done);
endinterface : asr_cnt_if

// ===== verilog/asr_timer.sv
// down counter that times pin phases
`timescale 1ns/1ps
module asr_timer (
  input  wire logic core_clk_i, // system clock
  input  wire logic srst_i,     // sync reset
  asr_cnt_if.tmr    tmr         // load and done
);
  logic [asr_pkg::CNT_W-1:0] cnt_reg;

  // reload wins over counting
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_reg <= asr_pkg::CNT_ZERO;
    end else if (tmr.load) begin
      cnt_reg <= tmr.value;
    end else if (cnt_reg != asr_pkg::CNT_ZERO) begin
      cnt_reg <= cnt_reg - asr_pkg::CNT_ONE;
    end
  end

  // done when one or zero left, so a phase lasts exactly value cycles;
  // done ignores load so the controller may reload in its done cycle
  // without a loop through its next-state logic
  assign tmr.done = (cnt_reg <= asr_pkg::CNT_ONE);
endmodule : asr_timer

// ===== verilog/asr_host.sv
// host controller driving an asynchronous 32k by 8 static ram
`timescale 1ns/1ps
// Functional notes
// - address set before write and held throughout strobe overlap; the code sets it on the same edge the strobe falls
// - data latched at first rising strobe edge; host holds data across it
// - only one ram selected at a time on the shared bus
// - keep output enable high while host drives write data
module asr_host (
  input  wire logic                        core_clk_i, // system clock
  input  wire logic                        srst_i,     // sync reset, active high
  input  wire logic                        req_i,      // access request
  input  wire logic                        we_i,       // 1 write, 0 read
  input  wire logic [asr_pkg::ADDR_W-1:0]  addr_i,     // word address
  input  wire logic [asr_pkg::DATA_W-1:0]  wdata_i,    // write byte
  output logic                             ready_o,    // accepts request
  output logic                             done_o,     // access finished pulse
  output logic [asr_pkg::DATA_W-1:0]       rdata_o,    // read byte
  output logic [asr_pkg::ADDR_W-1:0]       mem_addr_o, // ram address pins
  output logic                             mem_cs_n_o, // ram chip enable
  output logic                             mem_we_n_o, // ram write strobe
  output logic                             mem_oe_n_o, // ram output enable
  output logic [asr_pkg::DATA_W-1:0]       mem_dq_o,   // data out to ram
  output logic                             mem_dq_oe_o,// host drives data pins
  input  wire logic [asr_pkg::DATA_W-1:0]  mem_dq_i    // data pins in
);
  // slowest grade timing throughout: faster parts only lose some speed
  asr_pkg::asr_state_t             state_reg;
  asr_pkg::asr_state_t             state_next;
  logic [asr_pkg::DATA_W-1:0]      dq_s1_reg;
  logic [asr_pkg::DATA_W-1:0]      dq_s2_reg;
  logic                            done_reg;
  logic                            cs_n_reg;
  logic                            we_n_reg;
  logic                            oe_n_reg;
  logic                            dq_oe_reg;
  logic                            take;           // request accepted this edge
  logic                            rd_sel_next;    // next state is a read phase
  logic                            wr_strobe_next; // next state holds the strobe low
  logic                            wr_drive_next;  // next state drives write data
  // one timer serves the strobe, access and turnaround phases, phases never overlap
  asr_cnt_if                       cnt ();

  // read phases: enable and output enable low
  function automatic logic is_read_phase(input asr_pkg::asr_state_t s);
    return (s == asr_pkg::ASR_RSEL) || (s == asr_pkg::ASR_RWAIT);
  endfunction : is_read_phase

  // strobe phase: enable and write strobe low together
  function automatic logic is_strobe_phase(input asr_pkg::asr_state_t s);
    return (s == asr_pkg::ASR_WSTB);
  endfunction : is_strobe_phase

  // drive phases: strobe phase plus one cycle of data hold
  function automatic logic is_drive_phase(input asr_pkg::asr_state_t s);
    return (s == asr_pkg::ASR_WSTB) || (s == asr_pkg::ASR_WEND);
  endfunction : is_drive_phase

  // shared phase timer, counts down and flags the last cycle
  asr_timer u_timer (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .tmr        (cnt.tmr)
  );

  // pins are asynchronous to the clock: two flops before use
  // the byte stands still for many cycles before it is used, so no handshake
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      dq_s1_reg <= '0;
      dq_s2_reg <= '0;
    end else begin
      dq_s1_reg <= mem_dq_i;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // accept only from idle so address never moves mid access
  // combinational, so a request right after done is taken at once
  assign ready_o = (state_reg == asr_pkg::ASR_IDLE);
  assign take    = ready_o && req_i;

  // pin levels follow the next state so every pin is a plain flop output
  assign rd_sel_next    = is_read_phase(state_next);
  assign wr_strobe_next = is_strobe_phase(state_next);
  assign wr_drive_next  = is_drive_phase(state_next);

  // sequence: a timed phase ends when the timer reports done
  always_comb begin
    // default: stay in the current phase
    state_next = state_reg;
    case (state_reg)
      // wait for a request
      asr_pkg::ASR_IDLE: begin
        if (take) begin
          state_next = we_i ? asr_pkg::ASR_WSTB : asr_pkg::ASR_RSEL;
        end
      end
      // one cycle of select before the access count starts
      asr_pkg::ASR_RSEL:  state_next = asr_pkg::ASR_RWAIT;
      // access time plus the synchroniser delay
      asr_pkg::ASR_RWAIT: begin
        if (cnt.done) begin
          state_next = asr_pkg::ASR_TURN;
        end
      end
      // strobe low for setup and pulse width
      asr_pkg::ASR_WSTB: begin
        if (cnt.done) begin
          state_next = asr_pkg::ASR_WEND;
        end
      end
      // data kept on the pins one cycle past the strobe
      asr_pkg::ASR_WEND:  state_next = asr_pkg::ASR_TURN;
      // ram drivers float before the next access may start
      asr_pkg::ASR_TURN: begin
        if (cnt.done) begin
          state_next = asr_pkg::ASR_IDLE;
        end
      end
      // unused codes recover to idle
      default:            state_next = asr_pkg::ASR_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= asr_pkg::ASR_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // timer loads on every phase entry except the data hold and idle
  // a read loads zero at the take since the select cycle is not timed
  always_comb begin
    cnt.load  = 1'b0;
    cnt.value = asr_pkg::CNT_ZERO;
    // writes time the strobe from the take, reads the access from select,
    // and every way into turnaround times the ram output float
    if (take) begin
      cnt.load  = 1'b1;
      cnt.value = we_i ? 4'(asr_pkg::SETUP_CYC) : asr_pkg::CNT_ZERO;
    end else if (state_reg == asr_pkg::ASR_RSEL) begin
      cnt.load  = 1'b1;
      cnt.value = 4'(asr_pkg::ACC_CYC);
    end else if (state_next == asr_pkg::ASR_TURN && state_reg != asr_pkg::ASR_TURN) begin
      cnt.load  = 1'b1;
      cnt.value = 4'(asr_pkg::DIS_CYC);
    end
  end

  // address latched at request, stable until back in idle
  // write data rides with the address, so a busy request cannot touch either
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mem_addr_o <= '0;
      mem_dq_o   <= '0;
    end else if (take) begin
      mem_addr_o <= addr_i;
      mem_dq_o   <= wdata_i;
    end
  end

  // single chip enable, asserted only for this controller's access
  // write strobe falls together with chip enable, so ram stays floating
  // overlap of chip enable and strobe spans the write phase
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cs_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
    end else begin
      cs_n_reg <= !(rd_sel_next || wr_strobe_next);
      we_n_reg <= !wr_strobe_next;
    end
  end

  // strobe and enable rise together, data held one cycle more
  // output enable kept high whenever host drives the data pins
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      dq_oe_reg <= 1'b0;
      oe_n_reg  <= 1'b1;
    end else begin
      // write data stays one cycle past the strobe for hold time
      dq_oe_reg <= wr_drive_next;
      // read mode with strobe high and output enable low
      oe_n_reg  <= !rd_sel_next;
    end
  end

  // pins straight from flops, so no glitches reach the strobes
  assign mem_cs_n_o  = cs_n_reg;
  assign mem_we_n_o  = we_n_reg;
  assign mem_oe_n_o  = oe_n_reg;
  assign mem_dq_oe_o = dq_oe_reg;

  // sample before output enable rises; turnaround lets ram drivers float
  // the captured byte has been steady at the pins since the access time ran out
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_o  <= '0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg == asr_pkg::ASR_TURN) && cnt.done;
      if (state_reg == asr_pkg::ASR_RWAIT && cnt.done) begin
        rdata_o <= dq_s2_reg;
      end
    end
  end

  // one-cycle pulse once the ram has let go of the bus;
  // read data is already valid in the same cycle
  assign done_o = done_reg;
endmodule : asr_host

// ===== sim/asr_ram_model.sv
// behavioural model of the 32k by 8 static ram
`timescale 1ns/1ps
module asr_ram_model (
  input  wire logic       cs_n_i, we_n_i, oe_n_i, dq_oe_i, // controls
  input  wire logic [14:0] addr_i, // word address
  input  wire logic [7:0] dq_i,    // host data
  output logic      [7:0] dq_o     // shared pins
);
  logic [7:0] mem [32768];
  logic [7:0] hold = 8'h00;
  wire rd = !cs_n_i && we_n_i && !oe_n_i;
  wire wr = !cs_n_i && !we_n_i;
  always @(negedge wr) mem[addr_i] = dq_o;
  // floating pins show the inverse, not a stale byte
  always @(dq_o) if (rd || dq_oe_i) hold = dq_o;
  assign dq_o = (rd && dq_oe_i) ? 8'hxx : rd ? mem[addr_i] : dq_oe_i ? dq_i : ~hold;
endmodule : asr_ram_model

// ===== sim/asr_host_sva.sv
// pin checker for the ram host controller
`timescale 1ns/1ps
module asr_host_sva (
  input wire logic core_clk_i, srst_i, req_i, ready_o, done_o, // control
  input wire logic [asr_pkg::ADDR_W-1:0] mem_addr_o,           // address
  input wire logic mem_cs_n_o, mem_we_n_o, mem_oe_n_o, mem_dq_oe_o, // strobes
  input wire logic [asr_pkg::DATA_W-1:0] mem_dq_o              // data
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  a_wr_overlap: assert property (!mem_we_n_o |-> !mem_cs_n_o) else $error("strobe alone");
  a_addr_hold: assert property (!mem_cs_n_o && !$past(mem_cs_n_o) |-> $stable(mem_addr_o)) else $error("addr moved");
  a_data_hold: assert property ($rose(mem_we_n_o) |-> mem_dq_oe_o && $stable(mem_dq_o)) else $error("data moved");
  a_wr_pulse: assert property ($fell(mem_we_n_o) |-> !mem_we_n_o [*4]) else $error("strobe short");
  a_no_clash: assert property (mem_dq_oe_o |-> mem_oe_n_o) else $error("bus clash");
  a_read_mode: assert property (!mem_oe_n_o |-> mem_we_n_o && !mem_cs_n_o) else $error("bad read");
  a_rd_access: assert property ($fell(mem_oe_n_o) |-> !mem_oe_n_o [*8]) else $error("read short");
  a_we_with_cs: assert property ($fell(mem_we_n_o) |-> $fell(mem_cs_n_o)) else $error("strobe early");
  a_take_sel: assert property (req_i && ready_o |=> !mem_cs_n_o) else $error("no select");
  // main scenarios
  cover property ($rose(mem_we_n_o));
  cover property ($rose(mem_oe_n_o));
  cover property (done_o ##1 req_i && ready_o);
endmodule : asr_host_sva
bind asr_host asr_host_sva i_sva (.*);

// ===== sim/tb_asr_host.sv
// self-checking bench for the ram host controller
`timescale 1ns/1ps
module tb_asr_host;
  logic core_clk_i = 1'b0, srst_i = 1'b1, req_i = 1'b0, we_i = 1'b0;
  logic [14:0] addr_i = 15'h0, mem_addr_o;
  logic [7:0] wdata_i = 8'h00, rdata_o, mem_dq_o, mem_dq_i;
  logic ready_o, done_o, mem_cs_n_o, mem_we_n_o, mem_oe_n_o, mem_dq_oe_o;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  asr_host i_dut (.*);
  asr_ram_model i_ram (.cs_n_i(mem_cs_n_o), .we_n_i(mem_we_n_o), .oe_n_i(mem_oe_n_o),
    .dq_oe_i(mem_dq_oe_o), .addr_i(mem_addr_o), .dq_i(mem_dq_o), .dq_o(mem_dq_i));
  always #10 core_clk_i = ~core_clk_i;
  task chk(input string n, input logic [14:0] e, input logic [14:0] s);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task results;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // one access; poke raises a write request while busy
  task acc(input logic w, input logic [14:0] a, input logic [7:0] d, input logic poke);
    int n;
    @(posedge core_clk_i);
    req_i <= 1'b1; we_i <= w; addr_i <= a; wdata_i <= d;
    @(negedge core_clk_i); // an old done pulse has cleared by now
    for (n = 0; n < 40 && done_o !== 1'b1; n++) begin
      @(posedge core_clk_i);
      req_i <= poke && n > 1 && n < 5;
      we_i <= w | poke;
      wdata_i <= poke ? ~d : d;
      @(negedge core_clk_i);
    end
    chk("done", 15'h1, {14'h0, done_o});
  endtask : acc
  task t_idle;
    @(negedge core_clk_i);
    chk("idle", 15'h3a00, {1'b0, mem_cs_n_o, mem_we_n_o, mem_oe_n_o, mem_dq_oe_o, ready_o, done_o, rdata_o});
  endtask : t_idle
  task t_wr_rd;
    acc(1'b1, 15'h0, 8'ha5, 1'b0);
    acc(1'b1, 15'h7fff, 8'h3c, 1'b0);
    acc(1'b0, 15'h0, 8'h00, 1'b0);
    chk("rd lo", 15'ha5, {7'h0, rdata_o});
    acc(1'b0, 15'h7fff, 8'h00, 1'b0);
    chk("rd hi", 15'h3c, {7'h0, rdata_o});
  endtask : t_wr_rd
  // request while busy must be ignored
  task t_busy;
    acc(1'b0, 15'h7fff, 8'h00, 1'b1);
    chk("busy rd", 15'h3c, {7'h0, rdata_o});
    acc(1'b0, 15'h7fff, 8'h00, 1'b0);
    chk("no wr", 15'h3c, {7'h0, rdata_o});
  endtask : t_busy
  // reset mid-run clears the host, not the ram
  task t_reset;
    @(posedge core_clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    srst_i <= 1'b0;
    t_idle();
    acc(1'b0, 15'h0, 8'h00, 1'b0);
    chk("kept", 15'ha5, {7'h0, rdata_o});
  endtask : t_reset
  // hang guard well above the roughly 113 cycles the whole run takes
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk_i);
    srst_i <= 1'b0;
    t_idle();
    t_wr_rd();
    t_busy();
    t_reset();
    results();
  end
endmodule : tb_asr_host
